/* dv/bsc_chain_asserts.sv */
// checker on the boundary scan chain ports
`default_nettype none
module bsc_chain_asserts #(
  parameter LEN = 132
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // test link
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdi_pullup_en,
  input wire logic tap_shift,
  // pads
  input wire logic [LEN-1:0] pin_out,
  input wire logic [LEN-1:0] pin_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_rdy_pulse; pready |=> !pready; endproperty
  property p_rdy_time; psel && penable && !pready |=> pready; endproperty
  property p_err_rdy; pslverr |-> pready; endproperty
  property p_err_addr;
    pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c});
  endproperty
  property p_od_low;
    !(pin_oe[45] && pin_out[45] || pin_oe[49] && pin_out[49] ||
      pin_oe[115] && pin_out[115] || pin_oe[117] && pin_out[117]);
  endproperty
  property p_tdo_fall; $changed(tdo) |-> !tck; endproperty
  property p_shift_hold;
    tap_shift && $past(tap_shift, 6) |-> $stable(pin_out) && $stable(pin_oe);
  endproperty
  property p_pullup; $past(reset_n) |-> tdi_pullup_en; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  a_rdy_time: assert property (p_rdy_time) else $error("pready late");
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  a_err_addr: assert property (p_err_addr) else $error("pslverr wrong");
  a_od_low: assert property (p_od_low) else $error("open drain high");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved, tck high");
  a_shift_hold: assert property (p_shift_hold) else $error("pads moved in shift");
  a_pullup: assert property (p_pullup) else $error("pull-up off");
  c_err: cover property (pslverr);
  c_shift: cover property (tap_shift && $past(tap_shift, 6));
  c_od: cover property (pin_oe[45]);
endmodule
bind bsc_chain bsc_chain_asserts #(.LEN(LEN)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .tck(tck), .tdo(tdo), .tdi_pullup_en(tdi_pullup_en), .tap_shift(tap_shift),
  .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

/* dv/bsc_tester.sv */
// board test controller model driving the scan link
`default_nettype none
module bsc_tester (
  // link outputs
  output logic tck,
  output logic tdi,
  output logic tap_select,
  output logic tap_capture,
  output logic tap_shift,
  output logic tap_update,
  // link input
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_bit;
  initial begin
    {tck, tap_select, tap_capture, tap_shift, tap_update} = '0;
    tdi = 1'b1;
  end
  // one period; tdo taken just before the fall
  task automatic tick();
    #120 tck = 1'b1;
    #160 last_bit = tdo;
    tck = 1'b0;
    #40;
  endtask
  task automatic scan(input logic [131:0] din, output logic [131:0] dout);
    #7;
    tap_select = 1'b1;
    tap_capture = 1'b1;
    tick();
    tap_capture = 1'b0;
    tap_shift = 1'b1;
    for (int k = 0; k < 132; k++) begin
      tdi = din[k];
      tick();
      dout[k] = last_bit;
    end
    tdi = 1'b1;
    tap_shift = 1'b0;
    tap_update = 1'b1;
    tick();
    {tap_select, tap_update} = '0;
  endtask
endmodule
`default_nettype wire

/* dv/tb.sv */
// self-checking testbench for the boundary scan chain
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rdata;
  logic [131:0] core_out = '0, core_oe = '0, pin_in = '0, din, dout, m, e;
  wire [31:0] prdata;
  wire [131:0] pin_out, pin_oe;
  wire pready, pslverr, tck, tdi, tdo, tdo_oe, tdi_pullup_en;
  wire tap_select, tap_capture, tap_shift, tap_update;
  int miscompares = 0, comparisons = 0;
  int oe_cycles = 0;
  logic rerr;
  string kinds = {"444444444444444444444444444", "103110010010011110011001",
    "43434343434343434444444444444444232", "4343434343434343444444444",
    "101401010143043101031"};
  bsc_chain uut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tck(tck), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .tdi_pullup_en(tdi_pullup_en), .tap_select(tap_select), .tap_capture(tap_capture),
    .tap_shift(tap_shift), .tap_update(tap_update), .core_out(core_out),
    .core_oe(core_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  bsc_tester u_tst (.tck(tck), .tdi(tdi), .tap_select(tap_select),
    .tap_capture(tap_capture), .tap_shift(tap_shift), .tap_update(tap_update), .tdo(tdo));
  function automatic int kind(int i);
    return i < 132 ? kinds[i] - 48 : 0;
  endfunction
  function automatic int ctl_of(int i);
    if (i < 27 || i > 101 && i < 111 && i != 103 && i != 104) return 83;
    if (i > 66 && i < 83) return 85;
    if (i == 103 || i == 104 || i == 114) return 84;
    if (i == 28 || i == 129 || i > 50 && i < 101 || i == 121 || i == 124) return i + 1;
    return -1;
  endfunction
  function automatic logic od(int i);
    return i == 45 || i == 49 || i == 115 || i == 117;
  endfunction
  function automatic logic [131:0] rnd();
    logic [159:0] t;
    t = {$urandom, $urandom, $urandom, $urandom, $urandom};
    return t[131:0];
  endfunction
  // expected pads from update latches u
  task automatic pads(input logic [131:0] u);
    int c, k;
    for (int i = 0; i < 132; i++) begin
      c = ctl_of(i);
      k = kind(i);
      m[i] = (k == 0 || k == 4) && !od(i) && u[i];
      e[i] = od(i) ? !u[i] : (k == 0 || k == 4) && (c < 0 || u[c] == (kind(c) == 2));
    end
  endtask
  task automatic chk(input string what, input logic [131:0] x, input logic [131:0] y);
    comparisons++;
    if (y !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, x, y);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // cycles with the serial output driven, sampled mid-cycle
  always @(negedge clk_sys) begin
    if (tdo_oe === 1'b1) oe_cycles++;
  end
  initial begin
    #1000000;
    miscompares++;
    wrap_up();
  end
  initial begin
    void'($urandom(38));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctrl", 2, rdata);
    chk("ctrl err", 0, rerr);
    apb(0, 12'h0f0, 0);
    chk("unmapped", 0, rdata);
    chk("unmapped err", 1, rerr);
    for (int i = 0; i < 133; i++) begin
      apb(1, 12'h008, i);
      apb(0, 12'h00c, 0);
      chk("cell", {3'(kind(i)), kind(i) == 3, 1'b0}, rdata);
    end
    $display("test cell map done");
    core_out <= rnd();
    core_oe <= rnd();
    pin_in <= rnd();
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < 132; i++) begin
      m[i] = (kind(i) == 0 || kind(i) == 4) && !od(i) && core_out[i];
      e[i] = od(i) ? !core_out[i] : (kind(i) == 0 || kind(i) == 4) && core_oe[i];
    end
    chk("normal out", m, pin_out);
    chk("normal oe", e, pin_oe);
    $display("test normal done");
    apb(1, 12'h000, 3);
    din = rnd();
    u_tst.scan(din, dout);
    for (int i = 0; i < 132; i++) begin
      m[i] = 1'b1;
      e[i] = kind(i) == 1 || kind(i) == 4 ? pin_in[i] : kind(i) ? core_oe[i] : core_out[i];
    end
    chk("captured", e & m, dout & m);
    repeat (4) @(posedge clk_sys);
    pads(din);
    chk("test out", m, pin_out);
    chk("test oe", e, pin_oe);
    chk("tdo_oe cycles", 1056, oe_cycles);
    apb(0, 12'h004, 0);
    chk("shift count", 132, rdata[7:0]);
    $display("test scan done");
    apb(1, 12'h000, 1);
    u_tst.scan(~din, dout);
    repeat (4) @(posedge clk_sys);
    chk("held out", m, pin_out);
    chk("held oe", e, pin_oe);
    chk("idle tdo", {132{din[0]}}, dout);
    chk("held tdo_oe", 1056, oe_cycles);
    $display("test disabled chain done");
    wrap_up();
  end
endmodule
`default_nettype wire

/* rtl/bsc_cell.v */
// one boundary scan cell: capture/shift stage plus update latch
`include "bsc_defs.vh"
`default_nettype none

module bsc_cell #(
  parameter [2:0] KIND = `BSC_K_BIDIR
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // step enables
  input wire capture_en,
  input wire shift_en,
  input wire update_en,
  // data
  input wire capture_val,
  input wire scan_in,
  output reg stage,
  output reg upd,
  output wire enable_out
);

  // control cells park with their drivers off
  localparam [0:0] UPD_RST = (KIND == `BSC_K_CTL_LO) ? `BSC_UPD_RESET_LO : `BSC_UPD_RESET_HI;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage <= `BSC_STAGE_RESET;
    end else if (capture_en) begin
      stage <= capture_val;
    end else if (shift_en) begin
      stage <= scan_in;
    end
  end

  // latch moves only at the update step
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upd <= UPD_RST;
    end else if (update_en) begin
      upd <= stage;
    end
  end

  // low-active kind differs by one inverter and by its update latch resetting high
  assign enable_out = (KIND == `BSC_K_CTL_LO) ? ~upd : upd;

endmodule

`default_nettype wire

/* rtl/bsc_chain.v */
// boundary scan chain with apb access and pin multiplexing
`include "bsc_defs.vh"
`default_nettype none

module bsc_chain #(
  parameter LEN = `BSC_LEN
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // test link
  input wire tck,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe,
  output reg tdi_pullup_en,
  // tap controller state, tck domain
  input wire tap_select,
  input wire tap_capture,
  input wire tap_shift,
  input wire tap_update,
  // core side, one bit per cell position
  input wire [LEN-1:0] core_out,
  input wire [LEN-1:0] core_oe,
  // pads, one bit per cell position
  input wire [LEN-1:0] pin_in,
  output reg [LEN-1:0] pin_out,
  output reg [LEN-1:0] pin_oe
);

  // --------------------------------------------------------------------
  // cell map
  // --------------------------------------------------------------------
  // crystal and loop filter pins are absent from the map
  function [2:0] cell_kind;
    input integer i;
    begin
      if (i <= 26) cell_kind = `BSC_K_BIDIR;
      else if (i == 29 || i == 84 || i == 122 || i == 125 || i == 130)
        cell_kind = `BSC_K_CTL_LO;
      else if (i == 83 || i == 85) cell_kind = `BSC_K_CTL_HI;
      else if (i >= 51 && i <= 66)
        cell_kind = (i % 2 == 0) ? `BSC_K_CTL_LO : `BSC_K_BIDIR;
      else if (i >= 67 && i <= 82) cell_kind = `BSC_K_BIDIR;
      else if (i >= 86 && i <= 101)
        cell_kind = (i % 2 == 1) ? `BSC_K_CTL_LO : `BSC_K_BIDIR;
      else if ((i >= 102 && i <= 110) || i == 114 || i == 121 || i == 124)
        cell_kind = `BSC_K_BIDIR;
      else if (i == 28 || i == 32 || i == 33 || i == 35 || i == 36 || i == 38 ||
               i == 39 || i == 44 || i == 45 || i == 48 || i == 49 || i == 112 ||
               i == 115 || i == 117 || i == 119 || i == 123 || i == 127 || i == 129)
        cell_kind = `BSC_K_OLATCH;
      else cell_kind = `BSC_K_IPIN;
    end
  endfunction

  // governing control cell of each driven position
  function [7:0] cell_ctl;
    input integer i;
    begin
      if (i <= 26 || (i >= 102 && i <= 110 && i != 103 && i != 104))
        cell_ctl = `BSC_POS_ADDR_GROUP_OE;
      else if (i == 28) cell_ctl = `BSC_POS_TIMER_TWO_OE;
      else if (i >= 51 && i <= 66 && i % 2 == 1) cell_ctl = i[7:0] + 8'h01;
      else if (i >= 67 && i <= 82) cell_ctl = `BSC_POS_DATA_BUS_OE;
      else if (i >= 86 && i <= 101 && i % 2 == 0) cell_ctl = i[7:0] + 8'h01;
      else if (i == 103 || i == 104 || i == 114) cell_ctl = `BSC_POS_BUS_ERR_OE;
      else if (i == 121) cell_ctl = `BSC_POS_MODE_CLK_OE;
      else if (i == 124) cell_ctl = `BSC_POS_FETCH_OE;
      else if (i == 129) cell_ctl = `BSC_POS_TIMER_ONE_OE;
      else cell_ctl = `BSC_CTL_NONE;
    end
  endfunction

  // open-drain output latches: transfer done pins, halt, reset
  function cell_od;
    input integer i;
    begin
      cell_od = (i == 45 || i == 49 || i == 115 || i == 117);
    end
  endfunction

  // --------------------------------------------------------------------
  // synchronisers and test clock edges
  // --------------------------------------------------------------------
  wire [5:0] link_s;
  wire [LEN-1:0] pin_s;
  reg tck_d;
  wire tck_s = link_s[0];
  wire tdi_s = link_s[1];
  wire sel_s = link_s[2];
  wire cap_s = link_s[3];
  wire sh_s = link_s[4];
  wire upd_s = link_s[5];

  bsc_sync #(.WIDTH(6)) u_link_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in({tap_update, tap_shift, tap_capture, tap_select, tdi, tck}),
    .sync_out(link_s)
  );

  bsc_sync #(.WIDTH(LEN)) u_pin_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .async_in(pin_in),
    .sync_out(pin_s)
  );

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  // edges of the synchronised test clock
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;

  // --------------------------------------------------------------------
  // control registers
  // --------------------------------------------------------------------
  reg [1:0] ctrl;
  reg [7:0] cell_idx;
  reg [7:0] shift_count;
  wire test_drive = ctrl[`BSC_CTRL_TEST_DRIVE];
  // chain acts only while selected and enabled
  wire active = sel_s & ctrl[`BSC_CTRL_CHAIN_EN];
  wire do_capture = active & cap_s & tck_rise;
  wire do_shift = active & sh_s & tck_rise;
  wire do_update = active & upd_s & tck_fall;

  // --------------------------------------------------------------------
  // cells
  // --------------------------------------------------------------------
  wire [LEN-1:0] stage;
  wire [LEN-1:0] upd;
  wire [LEN-1:0] en;
  wire [LEN-1:0] next_pin_out;
  wire [LEN-1:0] next_pin_oe;

  genvar g;
  generate
    for (g = 0; g < LEN; g = g + 1) begin : g_cell
      localparam [2:0] K = cell_kind(g);
      localparam [7:0] C = cell_ctl(g);
      localparam OD = cell_od(g);
      wire scan_in;
      wire cap_val;
      wire grp_en;

      if (g == LEN - 1) begin : g_head
        assign scan_in = tdi_s;
      end else begin : g_link
        assign scan_in = stage[g+1];
      end

      if (C == `BSC_CTL_NONE) begin : g_free
        assign grp_en = 1'b1;
      end else begin : g_grp
        assign grp_en = en[C];
      end

      // inputs and bidir sample the pad, latches the core
      assign cap_val = (K == `BSC_K_IPIN || K == `BSC_K_BIDIR) ? pin_s[g] :
                       (K == `BSC_K_OLATCH) ? core_out[g] : core_oe[g];

      bsc_cell #(.KIND(K)) u_cell (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .capture_en(do_capture),
        .shift_en(do_shift),
        .update_en(do_update),
        .capture_val(cap_val),
        .scan_in(scan_in),
        .stage(stage[g]),
        .upd(upd[g]),
        .enable_out(en[g])
      );

      if (K == `BSC_K_OLATCH && OD) begin : g_od
        // only release or pull low
        assign next_pin_out[g] = 1'b0;
        assign next_pin_oe[g] = test_drive ? ~upd[g] : ~core_out[g];
      end else if (K == `BSC_K_OLATCH || K == `BSC_K_BIDIR) begin : g_drv
        assign next_pin_out[g] = test_drive ? upd[g] : core_out[g];
        assign next_pin_oe[g] = test_drive ? grp_en : core_oe[g];
      end else begin : g_quiet
        assign next_pin_out[g] = 1'b0;
        assign next_pin_oe[g] = 1'b0;
      end
    end
  endgenerate

  // pads change only from the update latches or core
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= {LEN{1'b0}};
      pin_oe <= {LEN{1'b0}};
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end

  // --------------------------------------------------------------------
  // serial output
  // --------------------------------------------------------------------
  // pull-up stays on whenever the block is out of reset
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tdi_pullup_en <= 1'b0;
    end else begin
      tdi_pullup_en <= 1'b1;
    end
  end

  // tdo only moves on a detected falling test clock edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= stage[0];
      tdo_oe <= active & sh_s;
    end
  end

  // --------------------------------------------------------------------
  // shift counter
  // --------------------------------------------------------------------
  // counts shifts since the last capture, wrapping at 256
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      shift_count <= 8'h00;
    end else if (do_capture) begin
      shift_count <= 8'h00;
    end else if (do_shift) begin
      shift_count <= shift_count + 8'h01;
    end
  end

  // --------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------
  wire access = psel & penable;
  wire write_done = access & pready & pwrite;
  reg [31:0] next_rdata;
  reg next_err;
  reg [2:0] sel_kind;

  always @* begin
    sel_kind = 3'h0;
    if (cell_idx < LEN) begin
      sel_kind = cell_kind(cell_idx);
    end
    next_rdata = 32'h0000_0000;
    next_err = 1'b0;
    case (paddr)
      `BSC_REG_CTRL: next_rdata = {30'h0, ctrl};
      `BSC_REG_STATUS: next_rdata = {22'h0, tdo, active, shift_count};
      `BSC_REG_CELL_IDX: next_rdata = {24'h0, cell_idx};
      `BSC_REG_CELL_DATA: begin
        if (cell_idx < LEN) begin
          next_rdata = {27'h0, sel_kind, upd[cell_idx], stage[cell_idx]};
        end
      end
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= next_err;
      if (!pwrite) begin
        prdata <= next_rdata;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  // write lands on the edge that completes the access
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `BSC_CTRL_RESET;
      cell_idx <= 8'h00;
    end else if (write_done) begin
      if (paddr == `BSC_REG_CTRL) begin
        ctrl <= pwdata[1:0];
      end
      if (paddr == `BSC_REG_CELL_IDX) begin
        cell_idx <= pwdata[7:0];
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/bsc_defs.vh */
// constants for the boundary scan chain
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH

// ----------------------------------------------------------------------
// chain geometry
// ----------------------------------------------------------------------
`define BSC_LEN 132
`define BSC_CTL_NONE 8'hff

// ----------------------------------------------------------------------
// cell kinds
// ----------------------------------------------------------------------
`define BSC_K_OLATCH 3'h0
`define BSC_K_IPIN 3'h1
`define BSC_K_CTL_HI 3'h2
`define BSC_K_CTL_LO 3'h3
`define BSC_K_BIDIR 3'h4

// ----------------------------------------------------------------------
// fixed control cell positions
// ----------------------------------------------------------------------
`define BSC_POS_TIMER_TWO_OE 8'h1d
`define BSC_POS_LEVEL7_IRQ_OE 8'h34
`define BSC_POS_ADDR_GROUP_OE 8'h53
`define BSC_POS_BUS_ERR_OE 8'h54
`define BSC_POS_DATA_BUS_OE 8'h55
`define BSC_POS_MODE_CLK_OE 8'h7a
`define BSC_POS_FETCH_OE 8'h7d
`define BSC_POS_TIMER_ONE_OE 8'h82

// ----------------------------------------------------------------------
// apb register map
// ----------------------------------------------------------------------
`define BSC_REG_CTRL 12'h000
`define BSC_REG_STATUS 12'h004
`define BSC_REG_CELL_IDX 12'h008
`define BSC_REG_CELL_DATA 12'h00c

// ctrl fields
`define BSC_CTRL_TEST_DRIVE 0
`define BSC_CTRL_CHAIN_EN 1
`define BSC_CTRL_RESET 2'h2

// reset values of the cell stages and update latches
`define BSC_STAGE_RESET 1'h0
`define BSC_UPD_RESET_HI 1'h0
`define BSC_UPD_RESET_LO 1'h1

`endif

/* rtl/bsc_sync.v */
// two flip-flop synchroniser for signals from outside the clock domain
`default_nettype none

module bsc_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // data
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire
